// ===== core/pcrm_pkg.sv
// Constants of the proximity converter register bank
package pcrm_pkg;

  // ****************************************
  // Pointers, channel 1 in slot 0
  // ****************************************
  localparam logic [7:0] PTR_STATUS = 8'h00;
  localparam logic [1:0][7:0] PTR_RES_HI = {8'h03, 8'h01};
  localparam logic [1:0][7:0] PTR_RES_LO = {8'h04, 8'h02};
  localparam logic [1:0][7:0] PTR_MEAN_HI = {8'h07, 8'h05};
  localparam logic [1:0][7:0] PTR_MEAN_LO = {8'h08, 8'h06};
  localparam logic [1:0][7:0] PTR_BAND = {8'h0c, 8'h09};
  localparam logic [1:0][7:0] PTR_EXPIRY = {8'h0d, 8'h0a};
  localparam logic [1:0][7:0] PTR_SETUP = {8'h0e, 8'h0b};
  localparam logic [1:0][7:0] PTR_DAC = {8'h12, 8'h11};
  localparam logic [7:0] PTR_CONFIG = 8'h0f;
  localparam logic [7:0] PTR_TIMER = 8'h10;
  localparam logic [7:0] PTR_SERIAL3 = 8'h13;
  localparam logic [7:0] PTR_SERIAL2 = 8'h14;
  localparam logic [7:0] PTR_SERIAL1 = 8'h15;
  localparam logic [7:0] PTR_SERIAL0 = 8'h16;
  localparam logic [7:0] PTR_PART_ID = 8'h17;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] STATUS_RESET = 8'h53;
  localparam logic [7:0] SENSE_RESET = 8'h08;
  localparam logic [7:0] EXPIRY_RESET = 8'h86;
  localparam logic [7:0] LIMIT_HI_RESET = 8'h08;
  localparam logic [7:0] LIMIT_LO_RESET = 8'h86;
  localparam logic [7:0] SETUP_RESET = 8'h0b;
  localparam logic [7:0] DAC_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h19;
  localparam logic [7:0] TIMER_RESET = 8'h00;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int ST_SLEEP = 7;
  localparam logic [1:0][2:0] ST_STEP = {3'h6, 3'h4};
  localparam logic [1:0][2:0] ST_DETECT = {3'h5, 3'h3};
  localparam int ST_LAST_CH = 2;
  localparam logic [1:0][2:0] ST_NOT_READY = {3'h1, 3'h0};
  localparam int CFG_CONST_LIMIT = 7;
  localparam int DAC_BITS = 6;
  localparam int RESULT_BITS = 12;
  localparam logic [3:0] PAD_ZERO = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage

// ===== core/pcrm_register_map.sv
// Two-wire serial slave and register bank of the proximity converter
`timescale 1ns/100ps

// Behaviour
// R1: Status at pointer 0x00, resets to 0x53
// R2: Status readable over the two-wire serial link
// R3: Status bits: sleep, steps, detects, channel, ready
// R4: Result high/low bytes per channel, reset zero
// R5: Running mean high/low bytes, reset zero
// R6: Setup byte: range, hysteresis, settling, reset 0x0b
// R7: Serial number MSB first, then part identification
// R8: Limit registers reachable only in constant-limit mode
// R9: Not-ready drops on conversion, rises on read
// R10: Result left aligned, low nibble reads zero
// R11: Result frozen while read runs until stop
// R12: Writes to read-only pointers do nothing
module pcrm_register_map #(
  parameter logic [6:0] SLAVE_ADDR = 7'h48,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic convDone,
  input wire logic convChannel,
  input wire logic [11:0] convResult,
  input wire logic [11:0] convMean,
  input wire logic convDetect,
  input wire logic convDacChanged,
  input wire logic [5:0] convDacValue,
  input wire logic sleepActive,
  output logic [15:0] chSense,
  output logic [15:0] chExpiry,
  output logic [31:0] chLimit,
  output logic [15:0] chSetup,
  output logic [15:0] chOffsetDac,
  output logic [7:0] deviceConfig,
  output logic [7:0] sleepTimer
);

  typedef enum logic [2:0] {
    sIdle, sAddr, sAddrAck, sWrite, sWriteAck, sRead, sReadAck
  } pcrm_i2c_state_t;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rstPipe; // Reset release chain
  logic rstn; // Synchronised reset, active low
  logic [1:0] sclSync; // Clock pin chain
  logic [1:0] sdaSync; // Data pin chain
  logic sclPrev; // Delayed second stage, edge finder
  logic sdaPrev;

  // Release chain, assert is immediate
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else if (ce) begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstn = rstPipe[1];

  // Pins idle high, so chains reset high
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (ce) begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaPin};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  // ****************************************
  // Bus conditions
  // ****************************************
  wire sclRise = sclSync[1] & ~sclPrev;
  wire sclFall = ~sclSync[1] & sclPrev;
  wire busHigh = sclSync[1] & sclPrev;
  wire startCond = busHigh & sdaPrev & ~sdaSync[1];
  wire stopCond = busHigh & ~sdaPrev & sdaSync[1];

  // ****************************************
  // Serial slave state
  // ****************************************
  pcrm_i2c_state_t stateReg, stateNext;
  logic [3:0] bitCntReg, bitCntNext; // Bits moved in this byte
  logic [7:0] shiftReg, shiftNext; // Shared rx/tx shifter
  logic [7:0] ptrReg, ptrNext; // Register pointer
  logic havePtrReg, havePtrNext; // First write byte seen
  logic rwReg, rwNext; // High for a read transfer
  logic ackReg, ackNext; // Master acked last byte
  logic sdaOeReg, sdaOeNext; // Pulling data low
  logic [7:0] readByte; // Byte at the pointer

  wire byteFull = bitCntReg == pcrm_pkg::BITS_PER_BYTE;
  wire addrHit = shiftReg[7:1] == SLAVE_ADDR;
  // Next byte leaves on the falling edge after an ack
  wire rdLoad = sclFall & ((stateReg == sAddrAck & rwReg)
              | (stateReg == sReadAck & ackReg));
  // Bytes after the pointer byte are register writes
  wire wrStrobe = ce & sclFall & stateReg == sWrite & byteFull
                & havePtrReg;
  wire fixedMode = deviceConfig[pcrm_pkg::CFG_CONST_LIMIT];

  // Next-state logic of the slave
  always_comb begin
    stateNext = stateReg;
    bitCntNext = bitCntReg;
    shiftNext = shiftReg;
    ptrNext = ptrReg;
    havePtrNext = havePtrReg;
    rwNext = rwReg;
    ackNext = ackReg;
    sdaOeNext = sdaOeReg;
    if (stopCond) begin
      // Stop ends any transfer, release the line
      stateNext = sIdle;
      sdaOeNext = 1'b0;
    end else if (startCond) begin
      // Start or repeated start, expect an address
      stateNext = sAddr;
      bitCntNext = 4'h0;
      havePtrNext = 1'b0;
      sdaOeNext = 1'b0;
    end else begin
      unique case (stateReg)
        sIdle: begin
          stateNext = sIdle;
        end
        sAddr, sWrite: begin
          if (sclRise) begin
            // Sample on rising edge, MSB first
            shiftNext = {shiftReg[6:0], sdaSync[1]};
            bitCntNext = bitCntReg + 4'h1;
          end else if (sclFall && byteFull) begin
            bitCntNext = 4'h0;
            if (stateReg == sAddr) begin
              // Foreign address leaves the bus alone
              sdaOeNext = addrHit;
              rwNext = shiftReg[0];
              stateNext = addrHit ? sAddrAck : sIdle;
            end else begin
              sdaOeNext = 1'b1;
              stateNext = sWriteAck;
              havePtrNext = 1'b1;
              // Pointer byte, or auto-increment after a write
              ptrNext = havePtrReg ? ptrReg + 8'h1 : shiftReg;
            end
          end
        end
        sAddrAck, sWriteAck, sReadAck: begin
          if (sclRise && stateReg == sReadAck) begin
            // Low data means the master wants more
            ackNext = ~sdaSync[1];
          end else if (rdLoad) begin
            shiftNext = readByte;
            sdaOeNext = ~readByte[7];
            bitCntNext = 4'h0;
            ptrNext = ptrReg + 8'h1;
            stateNext = sRead;
          end else if (sclFall) begin
            // Nack ends the read, wait for stop
            sdaOeNext = 1'b0;
            stateNext = (stateReg == sReadAck) ? sIdle : sWrite;
          end
        end
        sRead: begin
          if (sclRise) begin
            bitCntNext = bitCntReg + 4'h1;
          end else if (sclFall && byteFull) begin
            // Free the line for the master ack
            sdaOeNext = 1'b0;
            stateNext = sReadAck;
          end else if (sclFall) begin
            shiftNext = {shiftReg[6:0], 1'b0};
            sdaOeNext = ~shiftReg[6];
          end
        end
      endcase
    end
  end

  // Slave registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stateReg <= sIdle;
      bitCntReg <= 4'h0;
      shiftReg <= 8'h00;
      ptrReg <= pcrm_pkg::PTR_STATUS;
      havePtrReg <= 1'b0;
      rwReg <= 1'b0;
      ackReg <= 1'b0;
      sdaOeReg <= 1'b0;
    end else if (ce) begin
      stateReg <= stateNext;
      bitCntReg <= bitCntNext;
      shiftReg <= shiftNext;
      ptrReg <= ptrNext;
      havePtrReg <= havePtrNext;
      rwReg <= rwNext;
      ackReg <= ackNext;
      sdaOeReg <= sdaOeNext;
    end
  end
  assign sdaOe = sdaOeReg;
  assign sdaOut = 1'b0; // Open drain, only ever pulls low

  // ****************************************
  // Register storage
  // ****************************************
  logic [1:0][7:0] senseReg, expiryReg, limitHiReg, limitLoReg;
  logic [1:0][7:0] setupReg, dacReg;
  logic [1:0][11:0] resultReg, meanReg; // 12-bit samples
  logic [1:0] detectReg, stepReg, notReadyReg, lockReg, readHit;
  logic lastChReg, sleepReg;
  logic [7:0] configReg, timerReg;
  logic [7:0] statusByte;

  assign chSense = senseReg;
  assign chExpiry = expiryReg;
  assign chLimit = {limitHiReg[1], limitLoReg[1],
                    limitHiReg[0], limitLoReg[0]};
  assign chSetup = setupReg;
  assign chOffsetDac = dacReg;
  assign deviceConfig = configReg;
  assign sleepTimer = timerReg;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      wire convHit = convDone & (convChannel == 1'(ch));
      wire bandHit = wrStrobe & ptrReg == pcrm_pkg::PTR_BAND[ch];
      wire expHit = wrStrobe & ptrReg == pcrm_pkg::PTR_EXPIRY[ch];
      // A read of either result byte arms the freeze
      assign readHit[ch] = ce & rdLoad
        & (ptrReg == pcrm_pkg::PTR_RES_HI[ch]
        | ptrReg == pcrm_pkg::PTR_RES_LO[ch]);

      // Host-written settings of this channel
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          senseReg[ch] <= pcrm_pkg::SENSE_RESET;
          expiryReg[ch] <= pcrm_pkg::EXPIRY_RESET;
          limitHiReg[ch] <= pcrm_pkg::LIMIT_HI_RESET;
          limitLoReg[ch] <= pcrm_pkg::LIMIT_LO_RESET;
          setupReg[ch] <= pcrm_pkg::SETUP_RESET; // [R6]
          dacReg[ch] <= pcrm_pkg::DAC_RESET;
        end else if (ce) begin
          // Mode bit picks which pair the pointer reaches
          if (bandHit && fixedMode) limitHiReg[ch] <= shiftReg; // [R8]
          if (bandHit && !fixedMode) senseReg[ch] <= shiftReg; // [R8]
          if (expHit && fixedMode) limitLoReg[ch] <= shiftReg; // [R8]
          if (expHit && !fixedMode) expiryReg[ch] <= shiftReg; // [R8]
          if (wrStrobe && ptrReg == pcrm_pkg::PTR_SETUP[ch]) begin
            setupReg[ch] <= shiftReg; // [R6]
          end
          if (wrStrobe && ptrReg == pcrm_pkg::PTR_DAC[ch]) begin
            dacReg[ch] <= shiftReg;
          end
          // Auto adjust wins the low six bits over a host write in the same cycle
          if (convHit && convDacChanged) begin
            dacReg[ch][pcrm_pkg::DAC_BITS-1:0] <= convDacValue;
          end
        end
      end

      // Converter results and status of this channel
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          resultReg[ch] <= 12'h000; // [R4]
          meanReg[ch] <= 12'h000; // [R5]
          detectReg[ch] <= 1'b0;
          stepReg[ch] <= 1'b1;
          notReadyReg[ch] <= 1'b1; // [R9]
          lockReg[ch] <= 1'b0;
        end else if (ce) begin
          if (stopCond) lockReg[ch] <= 1'b0; // [R11]
          if (readHit[ch]) begin
            lockReg[ch] <= 1'b1; // [R11]
            notReadyReg[ch] <= 1'b1; // [R9]
          end
          if (convHit) begin
            meanReg[ch] <= convMean; // [R5]
            detectReg[ch] <= convDetect;
            stepReg[ch] <= ~convDacChanged; // Low means stepped
          end
          // A frozen result drops the new result; mean, detect and step still update
          if (convHit && !lockReg[ch]) begin
            resultReg[ch] <= convResult; // [R4] [R11]
            notReadyReg[ch] <= 1'b0; // [R9]
          end
        end
      end

      // Status bits of this channel
      assign statusByte[pcrm_pkg::ST_STEP[ch]] = stepReg[ch]; // [R3]
      assign statusByte[pcrm_pkg::ST_DETECT[ch]] = detectReg[ch]; // [R3]
      assign statusByte[pcrm_pkg::ST_NOT_READY[ch]] =
        notReadyReg[ch]; // [R3]
    end
  endgenerate

  // Device-wide settings and status
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      configReg <= pcrm_pkg::CONFIG_RESET;
      timerReg <= pcrm_pkg::TIMER_RESET;
      lastChReg <= 1'b0;
      sleepReg <= 1'b0;
    end else if (ce) begin
      if (wrStrobe && ptrReg == pcrm_pkg::PTR_CONFIG) begin
        configReg <= shiftReg;
      end
      if (wrStrobe && ptrReg == pcrm_pkg::PTR_TIMER) begin
        timerReg <= shiftReg;
      end
      if (convDone) lastChReg <= convChannel;
      sleepReg <= sleepActive;
    end
  end
  assign statusByte[pcrm_pkg::ST_SLEEP] = sleepReg; // [R3]
  assign statusByte[pcrm_pkg::ST_LAST_CH] = lastChReg; // [R3]

  // ****************************************
  // Read selection
  // ****************************************
  // Unmapped pointers read zero; read-only ones have no write path [R12]
  always_comb begin
    readByte = 8'h00;
    case (ptrReg)
      pcrm_pkg::PTR_STATUS: readByte = statusByte; // [R1] [R2]
      pcrm_pkg::PTR_RES_HI[0]: readByte = resultReg[0][11:4];
      pcrm_pkg::PTR_RES_LO[0]:
        readByte = {resultReg[0][3:0], pcrm_pkg::PAD_ZERO}; // [R10]
      pcrm_pkg::PTR_RES_HI[1]: readByte = resultReg[1][11:4];
      pcrm_pkg::PTR_RES_LO[1]:
        readByte = {resultReg[1][3:0], pcrm_pkg::PAD_ZERO}; // [R10]
      pcrm_pkg::PTR_MEAN_HI[0]: readByte = meanReg[0][11:4]; // [R5]
      pcrm_pkg::PTR_MEAN_LO[0]:
        readByte = {meanReg[0][3:0], pcrm_pkg::PAD_ZERO};
      pcrm_pkg::PTR_MEAN_HI[1]: readByte = meanReg[1][11:4];
      pcrm_pkg::PTR_MEAN_LO[1]:
        readByte = {meanReg[1][3:0], pcrm_pkg::PAD_ZERO};
      pcrm_pkg::PTR_BAND[0]:
        readByte = fixedMode ? limitHiReg[0] : senseReg[0]; // [R8]
      pcrm_pkg::PTR_EXPIRY[0]:
        readByte = fixedMode ? limitLoReg[0] : expiryReg[0];
      pcrm_pkg::PTR_SETUP[0]: readByte = setupReg[0];
      pcrm_pkg::PTR_BAND[1]:
        readByte = fixedMode ? limitHiReg[1] : senseReg[1];
      pcrm_pkg::PTR_EXPIRY[1]:
        readByte = fixedMode ? limitLoReg[1] : expiryReg[1];
      pcrm_pkg::PTR_SETUP[1]: readByte = setupReg[1];
      pcrm_pkg::PTR_CONFIG: readByte = configReg;
      pcrm_pkg::PTR_TIMER: readByte = timerReg;
      pcrm_pkg::PTR_DAC[0]: readByte = dacReg[0];
      pcrm_pkg::PTR_DAC[1]: readByte = dacReg[1];
      pcrm_pkg::PTR_SERIAL3: readByte = SERIAL_NUMBER[31:24]; // [R7]
      pcrm_pkg::PTR_SERIAL2: readByte = SERIAL_NUMBER[23:16];
      pcrm_pkg::PTR_SERIAL1: readByte = SERIAL_NUMBER[15:8];
      pcrm_pkg::PTR_SERIAL0: readByte = SERIAL_NUMBER[7:0];
      pcrm_pkg::PTR_PART_ID: readByte = PART_ID; // [R7]
      default: readByte = 8'h00;
    endcase
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_status_after_reset: assert property ( // [R1]
    $rose(rstn) |-> statusByte == pcrm_pkg::STATUS_RESET)
    else $error("status not at reset value");
  a_status_readout: assert property ( // [R2]
    rdLoad && ce && ptrReg == pcrm_pkg::PTR_STATUS
    |=> shiftReg == $past(statusByte))
    else $error("status byte not loaded for read");
  a_result_capture: assert property ( // [R4]
    ce && convDone && !convChannel && !lockReg[0]
    |=> resultReg[0] == $past(convResult))
    else $error("channel 1 result not captured");
  a_setup_default: assert property ( // [R6]
    $rose(rstn) |-> setupReg[1] == pcrm_pkg::SETUP_RESET)
    else $error("setup not at reset value");
  a_serial_msb: assert property ( // [R7]
    ptrReg == pcrm_pkg::PTR_SERIAL3 |-> readByte == SERIAL_NUMBER[31:24])
    else $error("serial byte order wrong");
  a_limit_hidden: assert property ( // [R8]
    wrStrobe && !fixedMode && ptrReg == pcrm_pkg::PTR_BAND[0]
    |=> $stable(limitHiReg[0]) && senseReg[0] == $past(shiftReg))
    else $error("limit written in adaptive mode");
  a_ready_drop: assert property ( // [R9]
    ce && convDone && convChannel && !lockReg[1] |=> !notReadyReg[1])
    else $error("not-ready did not drop");
  a_ready_rise: assert property ( // [R9]
    readHit[0] && !(convDone && !convChannel) |=> notReadyReg[0] ##0
    lockReg[0])
    else $error("read did not set not-ready");
  a_low_nibble: assert property ( // [R10]
    ptrReg == pcrm_pkg::PTR_RES_LO[1] |-> readByte[3:0] == 4'h0)
    else $error("low nibble not zero");
  a_result_frozen: assert property ( // [R11]
    lockReg[1] |=> $stable(resultReg[1]))
    else $error("result changed during read");
  a_ro_write: assert property ( // [R12]
    wrStrobe && ptrReg <= pcrm_pkg::PTR_MEAN_LO[1]
    |=> $stable(configReg) && $stable(setupReg))
    else $error("read-only write had an effect");

  c_read_start: cover property (rdLoad && ce && stateReg == sAddrAck);
  c_write_data: cover property (wrStrobe);
  c_sample_lost: cover property (convDone && ce && convChannel && lockReg[1]);
  c_read_chain: cover property (rdLoad && ce && stateReg == sReadAck);

endmodule

// ===== verif/pcrm_host_model.sv
// Behavioural two-wire serial master facing the register bank
`timescale 1ns/100ps

// ****************************************
// Host model
// ****************************************
module pcrm_host_model (
  input wire logic sys_clk,
  input wire logic sdaWire,
  output logic sclLine,
  output logic sdaLow,
  output logic [7:0] rdData,
  output logic rdToggle
);
  // Bus idles released, clock high
  initial begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
    rdData = 8'h00;
    rdToggle = 1'b0;
  end

  // One clock bit; data moves mid-low so it never races the clock fall
  task automatic bitCycle(input logic drive, output logic seen);
    repeat (5) @(negedge sys_clk);
    sdaLow = drive;
    repeat (5) @(negedge sys_clk);
    sclLine = 1'b1;
    repeat (5) @(negedge sys_clk);
    seen = sdaWire;
    repeat (5) @(negedge sys_clk);
    sclLine = 1'b0;
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic startCond();
    repeat (5) @(negedge sys_clk);
    sdaLow = 1'b0;
    repeat (5) @(negedge sys_clk);
    sclLine = 1'b1;
    repeat (5) @(negedge sys_clk);
    sdaLow = 1'b1;
    repeat (5) @(negedge sys_clk);
    sclLine = 1'b0;
  endtask

  // Stop: data rises while clock is high
  task automatic stopCond();
    repeat (5) @(negedge sys_clk);
    sdaLow = 1'b1;
    repeat (5) @(negedge sys_clk);
    sclLine = 1'b1;
    repeat (5) @(negedge sys_clk);
    sdaLow = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask

  // Byte out, MSB first; line released for the slave acknowledge
  task automatic sendByte(input logic [7:0] data, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(~data[i], s);
    end
    bitCycle(1'b0, ack);
  endtask

  // Byte in; masterAck high pulls the line low to ask for more
  task automatic recvByte(input logic masterAck, output logic [7:0] data);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b0, data[i]);
    end
    bitCycle(masterAck, s);
    rdData = data;
    rdToggle = ~rdToggle;
  endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the register bank over the serial link
`timescale 1ns/100ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [6:0] ADDR = 7'h48; // Bus address of the bank
  localparam logic [31:0] SER = 32'ha1b2_c3d4; // Arbitrary value
  localparam logic [7:0] PID = 8'h3c; // Arbitrary value
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic sclLine, sdaLow, sdaOut, sdaOe, rdToggle, sdaWire;
  logic [7:0] rdData, deviceConfig, sleepTimer;
  logic convDone = 1'b0, convChannel = 1'b0, convDetect = 1'b0;
  logic convDacChanged = 1'b0, sleepActive = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped in one scenario
  logic [11:0] convResult = 12'h000, convMean = 12'h000;
  logic [5:0] convDacValue = 6'h00;
  logic [15:0] chSense, chExpiry, chSetup, chOffsetDac;
  logic [31:0] chLimit;
  logic [7:0] expQ[$]; // Expected read bytes, oldest first
  int miscompares = 0;
  int total_checks = 0;

  always #5 sys_clk = ~sys_clk;
  // Pull-up wire: low when either side pulls
  assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));

  pcrm_register_map #(.SLAVE_ADDR(ADDR), .SERIAL_NUMBER(SER),
    .PART_ID(PID)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .sclPin(sclLine), .sdaPin(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convDone(convDone), .convChannel(convChannel),
    .convResult(convResult), .convMean(convMean), .convDetect(convDetect),
    .convDacChanged(convDacChanged), .convDacValue(convDacValue),
    .sleepActive(sleepActive), .chSense(chSense), .chExpiry(chExpiry),
    .chLimit(chLimit), .chSetup(chSetup), .chOffsetDac(chOffsetDac),
    .deviceConfig(deviceConfig), .sleepTimer(sleepTimer));
  pcrm_host_model host_u (.sys_clk(sys_clk), .sdaWire(sdaWire),
    .sclLine(sclLine), .sdaLow(sdaLow), .rdData(rdData),
    .rdToggle(rdToggle));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Address phase plus pointer byte
  task automatic setPtr(input logic [7:0] ptr);
    logic a;
    host_u.startCond();
    host_u.sendByte({ADDR, 1'b0}, a);
    check("address ack", a, 1'b0);
    host_u.sendByte(ptr, a);
  endtask

  // Burst read; last byte refused so the slave lets go
  task automatic readRun(input logic [7:0] ptr, input int n);
    logic [7:0] d;
    logic a;
    setPtr(ptr);
    host_u.startCond();
    host_u.sendByte({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      host_u.recvByte(i != n - 1, d);
    end
    host_u.stopCond();
  endtask

  task automatic writeRun(input logic [7:0] ptr, input logic [7:0] v[$]);
    logic a;
    setPtr(ptr);
    foreach (v[i]) begin
      host_u.sendByte(v[i], a);
    end
    host_u.stopCond();
  endtask

  // One conversion event; mean is the inverted result to tell them apart
  task automatic conv(input logic ch, input logic [11:0] res,
    input logic det, input logic chg, input logic [5:0] dv);
    @(negedge sys_clk);
    convChannel = ch;
    convResult = res;
    convMean = ~res;
    convDetect = det;
    convDacChanged = chg;
    convDacValue = dv;
    convDone = 1'b1;
    @(negedge sys_clk);
    convDone = 1'b0;
  endtask

  // Left-aligned 12-bit value as two bytes
  task automatic expWord(input logic [11:0] v);
    expQ.push_back(v[11:4]);
    expQ.push_back({v[3:0], 4'h0});
  endtask

  // ****************************************
  // Read watcher: oldest note against each byte read
  // ****************************************
  always @(rdToggle) begin
    if ($time > 0) begin
      if (expQ.size() == 0) begin
        check("spare read", 1'b1, 1'b0);
      end else begin
        check("read byte", rdData, expQ.pop_front());
      end
    end
  end

  // Watchdog, well past the expected run time
  initial begin
    #500_000;
    miscompares++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [11:0] r1, r2a, r2b;
    logic [5:0] dv;
    logic [7:0] w[$], lim[$], d;
    logic a;
    void'($urandom(86));
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (10) @(negedge sys_clk);
    // Whole map after reset
    w = '{8'h53, 0, 0, 0, 0, 0, 0, 0, 0, 8'h08, 8'h86, 8'h0b, 8'h08,
      8'h86, 8'h0b, 8'h19, 0, 0, 0, SER[31:24], SER[23:16], SER[15:8],
      SER[7:0], PID};
    foreach (w[i]) expQ.push_back(w[i]);
    readRun(8'h00, 24);
    // Channel 1 conversion with auto offset step, sleep raised
    r1 = 12'($urandom);
    dv = 6'($urandom);
    sleepActive = 1'b1;
    conv(1'b0, r1, 1'b1, 1'b1, dv);
    expQ.push_back(8'hca);
    readRun(8'h00, 1);
    expWord(r1);
    expWord(12'h000);
    expWord(~r1);
    readRun(8'h01, 6);
    expQ.push_back(8'hcb); // Not-ready flag back after the read
    readRun(8'h00, 1);
    expQ.push_back({2'b00, dv});
    readRun(8'h11, 1);
    // Channel 2: conversion lands in mid-read and its result is dropped
    r2a = 12'($urandom);
    r2b = 12'($urandom);
    conv(1'b1, r2a, 1'b0, 1'b0, 6'h00);
    expWord(r2a);
    setPtr(8'h03);
    host_u.startCond();
    host_u.sendByte({ADDR, 1'b1}, a);
    host_u.recvByte(1'b1, d);
    conv(1'b1, r2b, 1'b1, 1'b0, 6'h00);
    host_u.recvByte(1'b0, d);
    host_u.stopCond();
    expQ.push_back(8'hef);
    readRun(8'h00, 1);
    expWord(r2a);
    expWord(~r1);
    expWord(~r2b);
    readRun(8'h03, 6);
    // Foreign address gets no acknowledge
    host_u.startCond();
    host_u.sendByte({7'h49, 1'b0}, a);
    check("foreign ack", a, 1'b1);
    host_u.stopCond();
    // Channel settings in one auto-increment burst
    w = {};
    repeat (6) w.push_back(8'($urandom));
    writeRun(8'h09, w);
    check("sense", chSense, {w[3], w[0]});
    check("expiry", chExpiry, {w[4], w[1]});
    check("setup", chSetup, {w[5], w[2]});
    // Writes to read-only places change nothing
    writeRun(8'h00, '{8'hff, 8'h00, 8'hff});
    writeRun(8'h13, '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00});
    expQ.push_back(8'hef);
    expWord(r1);
    readRun(8'h00, 3);
    foreach (w[i]) if (i < 4) expQ.push_back(SER[31 - 8 * i -: 8]);
    expQ.push_back(PID);
    readRun(8'h13, 5);
    // Enable low freezes the bank, so this conversion is lost
    ce = 1'b0;
    conv(1'b0, ~r1, 1'b0, 1'b1, 6'h00);
    ce = 1'b1;
    expQ.push_back(8'hef);
    expWord(r1);
    readRun(8'h00, 3);
    // Constant-limit mode reaches the threshold storage
    writeRun(8'h0f, '{8'h99});
    check("config", deviceConfig, 8'h99);
    repeat (4) lim.push_back(8'($urandom));
    writeRun(8'h09, '{lim[0], lim[1]});
    writeRun(8'h0c, '{lim[2], lim[3]});
    check("limit", chLimit, {lim[2], lim[3], lim[0], lim[1]});
    check("sense kept", chSense, {w[3], w[0]});
    w = '{lim[0], lim[1], w[2], lim[2], lim[3], w[5], 8'h99, w[0], w[1]};
    foreach (w[i]) if (i < 7) expQ.push_back(w[i]);
    readRun(8'h09, 7);
    writeRun(8'h0f, '{8'h19});
    expQ.push_back(w[7]);
    expQ.push_back(w[8]);
    readRun(8'h09, 2);
    // Timer and offset DACs, then an unmapped pointer
    lim = {};
    repeat (3) lim.push_back(8'($urandom));
    writeRun(8'h10, lim);
    check("timer", sleepTimer, lim[0]);
    check("offset dac", chOffsetDac, {lim[2], lim[1]});
    writeRun(8'h20, '{8'h5a});
    expQ.push_back(8'h00);
    readRun(8'h20, 1);
    check("notes left", expQ.size(), 0);
    summarize();
  end
endmodule
